// >>> src/cbu_unit.sv
// Conditional skip and branch execution unit of the processor core.
`timescale 1ns/100ps
`default_nettype none
module cbu_unit (
   input  wire logic                        clk_in,             // Core clock, 100 MHz
   input  wire logic                        sys_rst_in,         // Synchronous reset, high
   input  wire logic                        instr_valid_in,     // Instruction offered
   input  wire logic [2:0]                  op_in,              // Operation code
   input  wire logic [cbu_pkg::PC_W-1:0]    pc_in,              // Address of instruction
   input  wire logic [cbu_pkg::OFS_W-1:0]   offset_in,          // Signed branch offset
   input  wire logic [cbu_pkg::IO_W-1:0]    io_data_in,         // Addressed I/O register
   input  wire logic [cbu_pkg::SEL_W-1:0]   bit_sel_in,         // I/O bit index
   input  wire logic [cbu_pkg::FLAG_W-1:0]  flags_in,           // Processor flag register
   input  wire logic [cbu_pkg::SEL_W-1:0]   flag_sel_in,        // Flag index
   input  wire logic                        next_two_word_in,   // Following instr is 2 words
   output logic [cbu_pkg::PC_W-1:0]         pc_out,             // Next program counter
   output logic                             pc_load_out,        // Load pc_out, one cycle
   output logic                             done_out,           // Instruction finished
   output logic                             busy_out,           // Stall fetch
   output logic                             taken_out,          // Last skip/branch taken
   output logic                             flag_we_out         // Flag write enable
);

   // ---------------------------------------------------------------
   // Condition evaluation
   // ---------------------------------------------------------------
   cbu_pkg::cbu_op_e             op;
   logic [cbu_pkg::SEL_W-1:0]    flag_idx;
   logic                         want;
   logic                         is_skip;
   logic                         io_hit;
   logic                         flag_hit;
   logic                         take;
   logic [1:0]                   cost;
   logic [cbu_pkg::PC_W-1:0]     ofs_ext;
   logic [cbu_pkg::PC_W-1:0]     target;

   always_comb begin
      op      = cbu_pkg::cbu_op_e'(op_in);
      ofs_ext = {{(cbu_pkg::PC_W-cbu_pkg::OFS_W){offset_in[cbu_pkg::OFS_W-1]}}, offset_in};
      is_skip = 1'b0;
      want    = 1'b1;
      flag_idx = flag_sel_in;
      unique case (op)
         cbu_pkg::OP_SKIP_ON_IO_BIT_LOW: begin
            is_skip = 1'b1;
            want    = 1'b0;
         end
         cbu_pkg::OP_SKIP_ON_IO_BIT_HIGH: begin
            is_skip = 1'b1;
         end
         cbu_pkg::OP_BRANCH_ON_FLAG_SET: begin
            want = 1'b1;
         end
         cbu_pkg::OP_BRANCH_ON_FLAG_CLEARED: begin
            want = 1'b0;
         end
         cbu_pkg::OP_BRANCH_ON_EQUAL: begin
            flag_idx = cbu_pkg::FLAG_Z_IDX;
         end
         cbu_pkg::OP_BRANCH_ON_NOT_EQUAL: begin
            flag_idx = cbu_pkg::FLAG_Z_IDX;
            want     = 1'b0;
         end
         cbu_pkg::OP_BRANCH_ON_CARRY_SET: begin
            flag_idx = cbu_pkg::FLAG_C_IDX;
         end
         cbu_pkg::OP_BRANCH_ON_CARRY_CLEARED: begin
            flag_idx = cbu_pkg::FLAG_C_IDX;
            want     = 1'b0;
         end
      endcase
   end

   cbu_bit_pick #(.W(cbu_pkg::IO_W), .SW(cbu_pkg::SEL_W)) u_io_pick (
      .data_in (io_data_in),
      .sel_in  (bit_sel_in),
      .want_in (want),
      .hit_out (io_hit)
   );

   cbu_bit_pick #(.W(cbu_pkg::FLAG_W), .SW(cbu_pkg::SEL_W)) u_flag_pick (
      .data_in (flags_in),
      .sel_in  (flag_idx),
      .want_in (want),
      .hit_out (flag_hit)
   );

   // The skip length depends on the word count of the following instruction,
   // which only fetch knows, so it is supplied alongside the skip itself.
   always_comb begin
      take   = is_skip ? io_hit : flag_hit;
      cost   = cbu_pkg::COST_ONE;
      target = pc_in + cbu_pkg::PC_STEP_ONE;
      if (take && is_skip) begin
         cost   = next_two_word_in ? cbu_pkg::COST_THREE : cbu_pkg::COST_TWO;
         target = pc_in + (next_two_word_in ? cbu_pkg::SKIP_TWO_WORD
                                            : cbu_pkg::SKIP_ONE_WORD);
      end else if (take) begin
         cost   = cbu_pkg::COST_TWO;
         target = pc_in + ofs_ext + cbu_pkg::PC_STEP_ONE;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   cbu_pkg::cbu_state_e          state_r, state_nxt;
   logic [1:0]                   remain_r, remain_nxt;
   logic [cbu_pkg::PC_W-1:0]     hold_r, hold_nxt;
   logic [cbu_pkg::PC_W-1:0]     pc_r, pc_nxt;
   logic                         load_r, load_nxt;
   logic                         done_r, done_nxt;
   logic                         busy_r, busy_nxt;
   logic                         taken_r, taken_nxt;
   logic                         flag_we_r, flag_we_nxt;

   always_comb begin
      state_nxt   = state_r;
      remain_nxt  = remain_r;
      hold_nxt    = hold_r;
      pc_nxt      = pc_r;
      load_nxt    = 1'b0;
      done_nxt    = 1'b0;
      busy_nxt    = busy_r;
      taken_nxt   = taken_r;
      flag_we_nxt = 1'b0;
      unique case (state_r)
         cbu_pkg::ST_IDLE: begin
            if (instr_valid_in) begin
               taken_nxt = take;
               if (cost == cbu_pkg::COST_ONE) begin
                  pc_nxt   = target;
                  load_nxt = 1'b1;
                  done_nxt = 1'b1;
               end else begin
                  state_nxt  = cbu_pkg::ST_WAIT;
                  remain_nxt = cost - cbu_pkg::COST_TWO;
                  hold_nxt   = target;
                  busy_nxt   = 1'b1;
               end
            end
         end
         cbu_pkg::ST_WAIT: begin
            if (remain_r == cbu_pkg::CNT_ZERO) begin
               state_nxt = cbu_pkg::ST_IDLE;
               pc_nxt    = hold_r;
               load_nxt  = 1'b1;
               done_nxt  = 1'b1;
               busy_nxt  = 1'b0;
            end else begin
               remain_nxt = remain_r - cbu_pkg::CNT_DEC;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_r   <= cbu_pkg::ST_IDLE;
         remain_r  <= cbu_pkg::CNT_ZERO;
         hold_r    <= cbu_pkg::PC_RESET;
         pc_r      <= cbu_pkg::PC_RESET;
         load_r    <= 1'b0;
         done_r    <= 1'b0;
         busy_r    <= 1'b0;
         taken_r   <= 1'b0;
         flag_we_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         remain_r  <= remain_nxt;
         hold_r    <= hold_nxt;
         pc_r      <= pc_nxt;
         load_r    <= load_nxt;
         done_r    <= done_nxt;
         busy_r    <= busy_nxt;
         taken_r   <= taken_nxt;
         flag_we_r <= flag_we_nxt;
      end
   end

   always_comb begin
      pc_out      = pc_r;
      pc_load_out = load_r;
      done_out    = done_r;
      busy_out    = busy_r;
      taken_out   = taken_r;
      flag_we_out = flag_we_r;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // Reference values are rebuilt from the raw inputs, not from the pickers,
   // so a slip in the condition logic shows up as a mismatch.
   logic                     acc;
   logic                     io_bit;
   logic [cbu_pkg::PC_W-1:0] ref_br;

   always_comb begin
      acc    = instr_valid_in && !busy_r;
      io_bit = io_data_in[bit_sel_in];
      ref_br = pc_in + {{(cbu_pkg::PC_W-cbu_pkg::OFS_W){offset_in[cbu_pkg::OFS_W-1]}},
                        offset_in} + cbu_pkg::PC_STEP_ONE;
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   a_skip_low_one: assert property (
      acc && op_in == cbu_pkg::OP_SKIP_ON_IO_BIT_LOW && !io_bit && !next_two_word_in
      |=> !done_r ##1 done_r && pc_r == $past(pc_in, 2) + cbu_pkg::SKIP_ONE_WORD)
      else $error("low-bit skip over one word wrong");

   a_skip_low_two: assert property (
      acc && op_in == cbu_pkg::OP_SKIP_ON_IO_BIT_LOW && !io_bit && next_two_word_in
      |=> !done_r [*2] ##1 done_r && pc_r == $past(pc_in, 3) + cbu_pkg::SKIP_TWO_WORD)
      else $error("low-bit skip over two words wrong");

   a_skip_high_one: assert property (
      acc && op_in == cbu_pkg::OP_SKIP_ON_IO_BIT_HIGH && io_bit && !next_two_word_in
      |=> busy_r ##1 done_r && pc_r == $past(pc_in, 2) + cbu_pkg::SKIP_ONE_WORD)
      else $error("high-bit skip wrong");

   a_skip_not_taken: assert property (
      acc && ((op_in == cbu_pkg::OP_SKIP_ON_IO_BIT_HIGH && !io_bit) ||
              (op_in == cbu_pkg::OP_SKIP_ON_IO_BIT_LOW && io_bit))
      |=> done_r && pc_load_out && pc_r == $past(pc_in) + cbu_pkg::PC_STEP_ONE)
      else $error("untaken skip not single cycle");

   a_br_set_taken: assert property (
      acc && op_in == cbu_pkg::OP_BRANCH_ON_FLAG_SET && flags_in[flag_sel_in]
      |=> !done_r ##1 done_r && taken_r && pc_r == $past(ref_br, 2))
      else $error("flag-set branch wrong");

   a_br_clr_taken: assert property (
      acc && op_in == cbu_pkg::OP_BRANCH_ON_FLAG_CLEARED && !flags_in[flag_sel_in]
      |=> !done_r ##1 done_r && pc_r == $past(ref_br, 2))
      else $error("flag-cleared branch wrong");

   a_br_zero_flag: assert property (
      acc && ((op_in == cbu_pkg::OP_BRANCH_ON_EQUAL && flags_in[cbu_pkg::FLAG_Z_IDX]) ||
              (op_in == cbu_pkg::OP_BRANCH_ON_NOT_EQUAL && !flags_in[cbu_pkg::FLAG_Z_IDX]))
      |=> ##1 done_r && pc_r == $past(ref_br, 2))
      else $error("zero-flag branch wrong");

   a_br_carry_flag: assert property (
      acc && ((op_in == cbu_pkg::OP_BRANCH_ON_CARRY_SET && flags_in[cbu_pkg::FLAG_C_IDX]) ||
              (op_in == cbu_pkg::OP_BRANCH_ON_CARRY_CLEARED && !flags_in[cbu_pkg::FLAG_C_IDX]))
      |=> ##1 done_r && pc_r == $past(ref_br, 2))
      else $error("carry-flag branch wrong");

   a_br_not_taken: assert property (
      acc && op_in == cbu_pkg::OP_BRANCH_ON_EQUAL && !flags_in[cbu_pkg::FLAG_Z_IDX]
      |=> done_r && !taken_r && pc_r == $past(pc_in) + cbu_pkg::PC_STEP_ONE)
      else $error("untaken branch not single cycle");

   a_flags_kept: assert property (
      $rose(done_r) || done_r |-> !flag_we_out && !$past(flag_we_out))
      else $error("flag write during skip or branch");

   a_done_bounded: assert property (
      acc |-> ##[1:3] done_r)
      else $error("instruction did not finish in three cycles");

   c_skip_three: cover property (
      acc && is_skip && take && next_two_word_in ##3 done_r);
   c_branch_taken: cover property (acc && !is_skip && take ##2 done_r);
   c_branch_not_taken: cover property (acc && !is_skip && !take ##1 done_r);
   c_back_to_back: cover property (done_r && acc);

endmodule : cbu_unit
`default_nettype wire

// >>> src/cbu_pkg.sv
// Constants and types shared by the conditional skip and branch unit.
//
// Summary of operation
// - Skip next instruction when tested I/O bit is zero; PC gains 2 or 3.
// - Skip next instruction when tested I/O bit is one; PC gains 2 or 3.
// - Branch on chosen flag set loads PC with PC plus offset plus one.
// - Branch on chosen flag cleared loads PC with PC plus offset plus one.
// - Equal branch tests zero flag set; not-equal branch tests it cleared.
// - Carry-cleared branch tests carry zero; carry-set branch tests carry one.
// - None of these instructions ever changes any status flag.
`default_nettype none
package cbu_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int PC_W   = 16;
   localparam int OFS_W  = 7;
   localparam int IO_W   = 8;
   localparam int FLAG_W = 8;
   localparam int SEL_W  = 3;

   // ---------------------------------------------------------------
   // Flag positions and program counter steps
   // ---------------------------------------------------------------
   localparam logic [SEL_W-1:0] FLAG_C_IDX     = 3'h0;
   localparam logic [SEL_W-1:0] FLAG_Z_IDX     = 3'h1;
   localparam logic [PC_W-1:0]  PC_STEP_ONE    = 16'h0001;
   localparam logic [PC_W-1:0]  SKIP_ONE_WORD  = 16'h0002;
   localparam logic [PC_W-1:0]  SKIP_TWO_WORD  = 16'h0003;
   localparam logic [PC_W-1:0]  PC_RESET       = 16'h0000;

   // ---------------------------------------------------------------
   // Cycle costs
   // ---------------------------------------------------------------
   localparam logic [1:0] COST_ONE   = 2'h1;
   localparam logic [1:0] COST_TWO   = 2'h2;
   localparam logic [1:0] COST_THREE = 2'h3;
   localparam logic [1:0] CNT_DEC    = 2'h1;
   localparam logic [1:0] CNT_ZERO   = 2'h0;

   typedef enum logic [2:0] {
      OP_SKIP_ON_IO_BIT_LOW,
      OP_SKIP_ON_IO_BIT_HIGH,
      OP_BRANCH_ON_FLAG_SET,
      OP_BRANCH_ON_FLAG_CLEARED,
      OP_BRANCH_ON_EQUAL,
      OP_BRANCH_ON_NOT_EQUAL,
      OP_BRANCH_ON_CARRY_SET,
      OP_BRANCH_ON_CARRY_CLEARED
   } cbu_op_e;

   typedef enum logic {
      ST_IDLE,
      ST_WAIT
   } cbu_state_e;

endpackage : cbu_pkg
`default_nettype wire

// >>> src/cbu_bit_pick.sv
// Bit selector that reports whether the chosen bit equals the wanted level.
`timescale 1ns/100ps
`default_nettype none
module cbu_bit_pick #(
   parameter int W  = 8,
   parameter int SW = 3
) (
   input  wire logic [W-1:0]  data_in,   // Vector to test
   input  wire logic [SW-1:0] sel_in,    // Bit index
   input  wire logic          want_in,   // Wanted level
   output logic               hit_out    // Chosen bit equals wanted level
);

   always_comb begin
      hit_out = (data_in[sel_in] == want_in);
   end

endmodule : cbu_bit_pick
`default_nettype wire

// >>> tb/cbu_pc_model.sv
// Program counter model that follows the unit's load strobe.
`timescale 1ns/100ps
`default_nettype none
module cbu_pc_model (
   input  wire logic                     clk_in,       // Core clock
   input  wire logic                     sys_rst_in,   // Synchronous reset, high
   input  wire logic                     pc_load_in,   // Load strobe from unit
   input  wire logic [cbu_pkg::PC_W-1:0] pc_next_in,   // Next address from unit
   output logic      [cbu_pkg::PC_W-1:0] pc_out        // Current program counter
);
   // ---------------------------------------------------------------
   // Program counter
   // ---------------------------------------------------------------
   logic [cbu_pkg::PC_W-1:0] pc_r;

   // The counter loads only on the strobe, so a missing load strobe is not hidden.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pc_r <= cbu_pkg::PC_RESET;
      end else if (pc_load_in) begin
         pc_r <= pc_next_in;
      end
   end

   assign pc_out = pc_r;
endmodule : cbu_pc_model
`default_nettype wire

// >>> tb/conditional_skip_branch_unit_tb.sv
// Self-checking bench for the conditional skip and branch unit.
`timescale 1ns/100ps
`default_nettype none
module conditional_skip_branch_unit_tb;
   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   logic        clk_in     = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        valid      = 1'b0;
   logic        two        = 1'b0;
   logic [2:0]  op         = 3'h0;
   logic [2:0]  bsel       = 3'h0;
   logic [2:0]  fsel       = 3'h0;
   logic [6:0]  ofs        = 7'h00;
   logic [7:0]  io         = 8'h00;
   logic [7:0]  flags      = 8'h00;
   logic [15:0] pc_cur;
   logic [15:0] pc_nx;
   logic        load;
   logic        done;
   logic        busy;
   logic        taken;
   logic        flag_we;
   logic [15:0] p_bb;
   int          n_mismatch = 0;
   int          checked    = 0;

   always #5 clk_in = ~clk_in;

   cbu_unit DUT (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .instr_valid_in(valid), .op_in(op),
      .pc_in(pc_cur), .offset_in(ofs), .io_data_in(io), .bit_sel_in(bsel),
      .flags_in(flags), .flag_sel_in(fsel), .next_two_word_in(two), .pc_out(pc_nx),
      .pc_load_out(load), .done_out(done), .busy_out(busy), .taken_out(taken),
      .flag_we_out(flag_we));

   cbu_pc_model u_pc (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pc_load_in(load),
      .pc_next_in(pc_nx), .pc_out(pc_cur));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   // One instruction; the unselected bits always hold the opposite level.
   task automatic run(input logic [2:0] o, input logic t, input logic w);
      logic [15:0] p;
      logic [15:0] e;
      logic [7:0]  m;
      logic [2:0]  ix;
      logic        want;
      int          cost;
      int          n;
      ix   = 3'(o * 3 + t + w);
      want = (o[0] ^ (o > 3'h1)) ? t : !t;
      m    = 8'h01 << ((o < 3'h4) ? ix : (o < 3'h6) ? cbu_pkg::FLAG_Z_IDX : cbu_pkg::FLAG_C_IDX);
      @(posedge clk_in);
      valid <= 1'b1;
      op    <= o;
      two   <= w;
      bsel  <= ix;
      fsel  <= ix;
      ofs   <= w ? 7'h40 : 7'h3f;
      io    <= (o > 3'h1) ? 8'h3c : (want ? m : ~m);
      flags <= (o < 3'h2) ? 8'ha5 : (want ? m : ~m);
      #1;
      p    = pc_cur;
      cost = !t ? 1 : (o < 3'h2) ? 2 + w : 2;
      e    = !t ? p + 16'h1 : (o < 3'h2) ? p + 16'h2 + {15'h0, w}
                            : p + {{9{ofs[6]}}, ofs} + 16'h1;
      @(posedge clk_in);
      valid <= 1'b0;
      n = 1;
      #1;
      while (done !== 1'b1 && n < 5) begin
         chk(16'(busy), 16'h1);
         @(posedge clk_in);
         n++;
         #1;
      end
      chk(16'(n), 16'(cost));
      chk(pc_nx, e);
      chk(16'(taken), 16'(t));
      chk(16'(load), 16'h1);
      chk(16'(busy), 16'h0);
      chk(16'(flag_we), 16'h0);
   endtask : run

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      for (int o = 0; o < 8; o++) begin
         for (int t = 0; t < 2; t++) begin
            for (int w = 0; w < 2; w++) begin
               run(3'(o), 1'(t), 1'(w));
            end
         end
      end
      // A reset that lands in the middle of a taken branch must clear everything.
      @(posedge clk_in);
      valid <= 1'b1;
      op    <= 3'h6;
      flags <= 8'hff;
      @(posedge clk_in);
      valid      <= 1'b0;
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1;
      chk(pc_nx, 16'h0000);
      chk({12'h000, load, done, busy, taken}, 16'h0000);
      @(posedge clk_in);
      sys_rst_in <= 1'b0;
      run(3'h4, 1'b1, 1'b0);
      // An untaken equal branch and a taken not-equal branch in back-to-back cycles.
      @(posedge clk_in);
      valid <= 1'b1;
      op    <= 3'h4;
      flags <= 8'h00;
      ofs   <= 7'h05;
      @(posedge clk_in);
      op    <= 3'h5;
      #1;
      p_bb = pc_cur;
      chk(16'(done), 16'h1);
      chk(pc_nx, p_bb + 16'h1);
      @(posedge clk_in);
      valid <= 1'b0;
      #1;
      chk(16'({busy, taken}), 16'h3);
      @(posedge clk_in);
      #1;
      chk(16'(done), 16'h1);
      chk(pc_nx, p_bb + 16'h6);
      print_verdict();
   end

   initial begin
      #20000;
      n_mismatch++;
      print_verdict();
   end
endmodule : conditional_skip_branch_unit_tb
`default_nettype wire
